// ===== logic/vsf_pkg.sv
// constants, encodings and helpers of the video scaler and pixel formatter
`default_nettype none
package vsf_pkg;
    // register offsets
    localparam logic [11:0] VSF_OFS_SCALER = 12'h008;
    localparam logic [11:0] VSF_OFS_TOP = 12'h00c;
    localparam logic [11:0] VSF_OFS_BOT = 12'h010;
    // scaler and format fields
    localparam int VSF_HFILT_LSB = 21;
    localparam int VSF_DUP_BIT = 20;
    localparam int VSF_HDCM_LSB = 14;
    localparam int VSF_VDCM_LSB = 8;
    localparam int VSF_DISP_BIT = 6;
    localparam int VSF_FMT_LSB = 3;
    localparam int VSF_DITH_BIT = 2;
    localparam int VSF_PACK_BIT = 1;
    localparam int VSF_LE_BIT = 0;
    localparam int VSF_RSVD_HI_BIT = 7;
    localparam int VSF_RSVD_LO_BIT = 5;
    // reset values and writable masks
    localparam logic [31:0] VSF_SCALER_RST = 32'h00000011;
    localparam logic [31:0] VSF_SCALER_WMASK = 32'h00ffff5f;
    localparam logic [31:0] VSF_BASE_RST = 32'h0ffffffc;
    localparam logic [31:0] VSF_BASE_WMASK = 32'hfffffffc;
    localparam logic [31:0] VSF_WORD_STEP = 32'h00000004;
    // decimation counters: a group of 64 is the carry of a 6-bit sum
    localparam int VSF_DCM_W = 6;
    // output formats
    localparam logic [1:0] VSF_FMT_YUV = 2'h0;
    localparam logic [1:0] VSF_FMT_RGB888 = 2'h1;
    localparam logic [1:0] VSF_FMT_RGB565 = 2'h2;
    localparam logic [1:0] VSF_FMT_RGB555 = 2'h3;
    // horizontal filter selector codes
    localparam logic [2:0] VSF_HF_C3 = 3'h0;
    localparam logic [2:0] VSF_HF_LC3 = 3'h1;
    localparam logic [2:0] VSF_HF_T4 = 3'h2;
    localparam logic [2:0] VSF_HF_L5C4 = 3'h3;
    localparam logic [2:0] VSF_HF_T4B = 3'h4;
    localparam logic [2:0] VSF_HF_DEFAULT = VSF_HF_C3;

    typedef enum logic [2:0] {
        VSF_TAP_NONE, VSF_TAP_3, VSF_TAP_4, VSF_TAP_5, VSF_TAP_4B
    } vsf_tap_t;

    // byte-lane write merge, writable bits only
    function automatic logic [31:0] vsf_merge(input logic [31:0] old,
            input logic [31:0] wd, input logic [3:0] be,
            input logic [31:0] wmask);
        logic [31:0] lane;
        lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        return (old & ~lane) | (wd & lane);
    endfunction : vsf_merge

    // causal fir over five samples, w[7:0] newest, result scaled by 1/8
    function automatic logic [7:0] vsf_fir(input logic [39:0] w,
            input vsf_tap_t k);
        logic [10:0] a0, a1, a2, a3, a4, s;
        a0 = {3'h0, w[7:0]};
        a1 = {3'h0, w[15:8]};
        a2 = {3'h0, w[23:16]};
        a3 = {3'h0, w[31:24]};
        a4 = {3'h0, w[39:32]};
        unique case (k)
            VSF_TAP_NONE: s = a0 << 3;
            VSF_TAP_3: s = (a0 + (a1 << 1) + a2) << 1;
            VSF_TAP_4: s = a0 + (a1 << 1) + a1 + (a2 << 1) + a2 + a3;
            VSF_TAP_5: s = a0 + ((a1 + a2 + a3) << 1) + a4;
            VSF_TAP_4B: s = (a0 + a1 + a2 + a3) << 1;
            default: s = a0 << 3;
        endcase
        return s[10:3];
    endfunction : vsf_fir
endpackage : vsf_pkg
`default_nettype wire

// ===== logic/vsf_decim.sv
// evenly spread drop decision: n drops out of every 64 steps
`default_nettype none
module vsf_decim (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // control
    input wire logic step_i,
    input wire logic load_i,
    input wire logic [vsf_pkg::VSF_DCM_W-1:0] load_val_i,
    input wire logic [vsf_pkg::VSF_DCM_W-1:0] count_i,
    // decision for the current step
    output logic drop_o
);
    import vsf_pkg::*;

    logic [VSF_DCM_W-1:0] acc_q;
    logic [VSF_DCM_W-1:0] base;
    logic [VSF_DCM_W:0] sum;

    // a carry out of the phase accumulator marks a drop, so n carries
    // fall evenly over 64 steps instead of one run
    assign base = load_i ? load_val_i : acc_q;
    assign sum = {1'b0, base} + {1'b0, count_i};
    assign drop_o = sum[VSF_DCM_W];

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            acc_q <= '0;
        end else if (step_i) begin
            acc_q <= sum[VSF_DCM_W-1:0];
        end
    end
endmodule : vsf_decim
`default_nettype wire

// ===== logic/vsf_rgb.sv
// colour conversion, error diffusion and 16-bit pixel formatting
`default_nettype none
module vsf_rgb (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // pixel from the scaler
    input wire logic en_i,
    input wire logic line_start_i,
    input wire logic [7:0] y_i,
    input wire logic [7:0] cb_i,
    input wire logic [7:0] cr_i,
    input wire logic [7:0] c_i,
    // configuration
    input wire logic [1:0] fmt_i,
    input wire logic dither_i,
    // formatted pixel
    output logic [15:0] pix16_o,
    output logic [23:0] rgb24_o
);
    import vsf_pkg::*;

    function automatic logic [7:0] clamp8(input logic signed [19:0] v);
        if (v < 20'sd0) begin
            return 8'h00;
        end else if (v > 20'sd255) begin
            return 8'hff;
        end
        return v[7:0];
    endfunction : clamp8

    function automatic logic [7:0] add_err(input logic [7:0] v,
            input logic [2:0] e);
        logic [8:0] s;
        s = {1'b0, v} + {6'h00, e};
        return s[8] ? 8'hff : s[7:0];
    endfunction : add_err

    logic signed [19:0] ys, dcb, dcr;
    logic [7:0] r8, g8, b8, rs, gs, bs;
    logic [2:0] er_q, eg_q, eb_q, er_in, eg_in, eb_in;
    logic dith_on;

    assign ys = signed'({12'h000, y_i});
    assign dcb = signed'({12'h000, cb_i}) - 20'sd128;
    assign dcr = signed'({12'h000, cr_i}) - 20'sd128;
    assign r8 = clamp8(ys + ((dcr * 20'sd359) >>> 8));
    assign g8 = clamp8(ys - ((dcb * 20'sd88 + dcr * 20'sd183) >>> 8));
    assign b8 = clamp8(ys + ((dcb * 20'sd454) >>> 8));

    // diffusion only means anything where bits are thrown away
    assign dith_on = dither_i &&
        (fmt_i == VSF_FMT_RGB565 || fmt_i == VSF_FMT_RGB555);
    // errors restart at each line so one line never leaks into the next
    assign er_in = (dith_on && !line_start_i) ? er_q : 3'h0;
    assign eg_in = (dith_on && !line_start_i) ? eg_q : 3'h0;
    assign eb_in = (dith_on && !line_start_i) ? eb_q : 3'h0;
    assign rs = add_err(r8, er_in);
    assign gs = add_err(g8, eg_in);
    assign bs = add_err(b8, eb_in);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            er_q <= 3'h0;
            eg_q <= 3'h0;
            eb_q <= 3'h0;
        end else if (en_i) begin
            er_q <= rs[2:0];
            eg_q <= (fmt_i == VSF_FMT_RGB565) ? {1'b0, gs[1:0]} : gs[2:0];
            eb_q <= bs[2:0];
        end
    end

    always_comb begin
        unique case (fmt_i)
            VSF_FMT_YUV: pix16_o = {c_i, y_i};
            VSF_FMT_RGB565: pix16_o = {rs[7:3], gs[7:2], bs[7:3]};
            VSF_FMT_RGB555: pix16_o = {1'b0, rs[7:3], gs[7:3], bs[7:3]};
            default: pix16_o = 16'h0000;
        endcase
    end
    assign rgb24_o = {r8, g8, b8};
endmodule : vsf_rgb
`default_nettype wire

// ===== logic/vsf_top.sv
// video scaler and pixel formatter with its three configuration registers
//
// Contract
// - the three-bit selector picks chroma-3, 3/3, 4/4, 5/4 or 4/4b taps.
// - selector codes 101b to 111b act exactly as the default code.
// - identical fields share the vertical drop phase, else offset it.
// - n pixels are dropped from every 64 on a line, none when n is 0.
// - n lines are dropped from every 64 lines, none when n is 0.
// - single-field mode writes top fields only, else both fields.
// - a two-bit field picks YUV 4:2:2, RGB 8:8:8, 5:6:5 or 5:5:5.
// - 5:6:5 and 5:5:5 use error diffusion when enabled, else truncate.
// - packed RGB 8:8:8 puts four pixels into three bus words.
// - without packing each bus word carries exactly one pixel.
// - the byte-order bit selects little-endian, else big-endian words.
// - top fields start at the word-aligned top base, low bits zero.
// - bottom fields start at the word-aligned bottom base, low bits 0.
// - bits 7 and 5 of the scaler register read zero and ignore writes.
`default_nettype none
module vsf_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // register access
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [3:0] reg_be_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // incoming yuv 4:2:2 pixels
    input wire logic pix_valid_i,
    output logic pix_ready_o,
    input wire logic [7:0] pix_y_i,
    input wire logic [7:0] pix_c_i,
    input wire logic pix_line_start_i,
    input wire logic pix_field_start_i,
    input wire logic pix_field_bottom_i,
    // display memory writes
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic [31:0] wr_data_o,
    output logic [31:0] wr_addr_o
);
    import vsf_pkg::*;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    logic [31:0] scaler_q, top_q, bot_q, rdata_q;
    logic rvalid_q, rd_scaler_q;
    logic [2:0] hsel, hsel_eff;
    logic [5:0] hdcm, vdcm;
    logic dup, disp_single, dither, pack, little, pack888;
    logic [1:0] fmt;
    vsf_tap_t luma_k, chroma_k;

    // registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            scaler_q <= VSF_SCALER_RST;
            top_q <= VSF_BASE_RST;
            bot_q <= VSF_BASE_RST;
        end else if (reg_wr_i) begin
            if ({reg_addr_i[11:2], 2'b00} == VSF_OFS_SCALER) begin
                scaler_q <= vsf_merge(scaler_q, reg_wdata_i, reg_be_i,
                    VSF_SCALER_WMASK);
            end
            if ({reg_addr_i[11:2], 2'b00} == VSF_OFS_TOP) begin
                top_q <= vsf_merge(top_q, reg_wdata_i, reg_be_i,
                    VSF_BASE_WMASK);
            end
            if ({reg_addr_i[11:2], 2'b00} == VSF_OFS_BOT) begin
                bot_q <= vsf_merge(bot_q, reg_wdata_i, reg_be_i,
                    VSF_BASE_WMASK);
            end
        end
    end

    // reads answer one cycle later; unmapped offsets return zero
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
            rd_scaler_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_i;
            rd_scaler_q <= reg_rd_i &&
                ({reg_addr_i[11:2], 2'b00} == VSF_OFS_SCALER);
            if (reg_rd_i) begin
                unique case ({reg_addr_i[11:2], 2'b00})
                    VSF_OFS_SCALER: rdata_q <= scaler_q;
                    VSF_OFS_TOP: rdata_q <= top_q;
                    VSF_OFS_BOT: rdata_q <= bot_q;
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end
    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;

    assign hsel = scaler_q[VSF_HFILT_LSB+:3];
    assign dup = scaler_q[VSF_DUP_BIT];
    assign hdcm = scaler_q[VSF_HDCM_LSB+:VSF_DCM_W];
    assign vdcm = scaler_q[VSF_VDCM_LSB+:VSF_DCM_W];
    assign disp_single = scaler_q[VSF_DISP_BIT];
    assign fmt = scaler_q[VSF_FMT_LSB+:2];
    assign dither = scaler_q[VSF_DITH_BIT];
    assign pack = scaler_q[VSF_PACK_BIT];
    assign little = scaler_q[VSF_LE_BIT];
    assign pack888 = pack && (fmt == VSF_FMT_RGB888);

    // filter choice
    assign hsel_eff = (hsel > VSF_HF_T4B) ? VSF_HF_DEFAULT : hsel;
    always_comb begin
        unique case (hsel_eff)
            VSF_HF_C3: begin
                luma_k = VSF_TAP_NONE;
                chroma_k = VSF_TAP_3;
            end
            VSF_HF_LC3: begin
                luma_k = VSF_TAP_3;
                chroma_k = VSF_TAP_3;
            end
            VSF_HF_T4: begin
                luma_k = VSF_TAP_4;
                chroma_k = VSF_TAP_4;
            end
            VSF_HF_L5C4: begin
                luma_k = VSF_TAP_5;
                chroma_k = VSF_TAP_4;
            end
            default: begin
                luma_k = VSF_TAP_4B;
                chroma_k = VSF_TAP_4B;
            end
        endcase
    end

    // input stage: the whole pipe stalls while a write is refused
    logic wr_valid_q, adv, acc_in, is_cr, ph_q;
    logic [39:0] y_hist_q, cb_hist_q, cr_hist_q, y_w, cb_w, cr_w;
    logic [7:0] y_f, cb_f, cr_f;
    assign adv = !wr_valid_q || wr_ready_i;
    assign pix_ready_o = adv;
    assign acc_in = pix_valid_i && adv;
    assign is_cr = pix_line_start_i ? 1'b0 : ph_q;
    assign y_w = {y_hist_q[31:0], pix_y_i};
    assign cb_w = is_cr ? cb_hist_q : {cb_hist_q[31:0], pix_c_i};
    assign cr_w = is_cr ? {cr_hist_q[31:0], pix_c_i} : cr_hist_q;
    // filtering runs ahead of decimation to keep aliasing down
    assign y_f = vsf_fir(y_w, luma_k);
    assign cb_f = vsf_fir(cb_w, chroma_k);
    assign cr_f = vsf_fir(cr_w, chroma_k);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ph_q <= 1'b0;
            y_hist_q <= '0;
            cb_hist_q <= '0;
            cr_hist_q <= '0;
        end else if (acc_in) begin
            ph_q <= !is_cr;
            y_hist_q <= y_w;
            cb_hist_q <= cb_w;
            cr_hist_q <= cr_w;
        end
    end

    // decimation and field selection
    logic hdrop, vdrop, line_drop_q, line_drop, fld_bot_q, bot_now;
    logic field_drop, keep, pend_ls_q, pend_fs_q;
    logic [5:0] vphase;
    // interlaced fields sit half a line apart, so the bottom field
    // starts its drop phase half a line's count (vdcm/2) ahead; equal fields share one pattern
    assign vphase = (pix_field_bottom_i && !dup) ? (vdcm >> 1) : 6'h00;

    vsf_decim u_hdec (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .step_i(acc_in),
        .load_i(pix_line_start_i),
        .load_val_i(6'h00),
        .count_i(hdcm),
        .drop_o(hdrop)
    );

    vsf_decim u_vdec (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .step_i(acc_in && pix_line_start_i),
        .load_i(pix_field_start_i),
        .load_val_i(vphase),
        .count_i(vdcm),
        .drop_o(vdrop)
    );

    assign line_drop = pix_line_start_i ? vdrop : line_drop_q;
    assign bot_now = pix_field_start_i ? pix_field_bottom_i : fld_bot_q;
    assign field_drop = disp_single && bot_now;
    assign keep = acc_in && !hdrop && !line_drop && !field_drop;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            line_drop_q <= 1'b0;
            fld_bot_q <= 1'b0;
            pend_ls_q <= 1'b0;
            pend_fs_q <= 1'b0;
        end else if (acc_in) begin
            line_drop_q <= line_drop;
            fld_bot_q <= bot_now;
            pend_ls_q <= !keep && (pend_ls_q || pix_line_start_i);
            pend_fs_q <= !keep && (pend_fs_q || pix_field_start_i);
        end
    end

    // stage a: kept pixel with its line and field marks
    logic a_valid_q, a_ls_q, a_fs_q, a_bot_q, a_en;
    logic [7:0] a_y_q, a_cb_q, a_cr_q, a_c_q;
    logic [15:0] pix16;
    logic [23:0] rgb24;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            a_valid_q <= 1'b0;
            a_ls_q <= 1'b0;
            a_fs_q <= 1'b0;
            a_bot_q <= 1'b0;
            a_y_q <= 8'h00;
            a_cb_q <= 8'h00;
            a_cr_q <= 8'h00;
            a_c_q <= 8'h00;
        end else if (adv) begin
            a_valid_q <= keep;
            a_ls_q <= pix_line_start_i || pend_ls_q;
            a_fs_q <= pix_field_start_i || pend_fs_q;
            a_bot_q <= bot_now;
            a_y_q <= y_f;
            a_cb_q <= cb_f;
            a_cr_q <= cr_f;
            a_c_q <= is_cr ? cr_f : cb_f;
        end
    end
    assign a_en = adv && a_valid_q;

    vsf_rgb u_rgb (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .en_i(a_en),
        .line_start_i(a_ls_q),
        .y_i(a_y_q),
        .cb_i(a_cb_q),
        .cr_i(a_cr_q),
        .c_i(a_c_q),
        .fmt_i(fmt),
        .dither_i(dither),
        .pix16_o(pix16),
        .rgb24_o(rgb24)
    );

    // word forming: packing, byte order and destination address
    logic [1:0] pk_ph_q, pk_ph;
    logic [15:0] res_q;
    logic [31:0] word, word_bo, wptr_q, cur_addr;
    logic emit;
    assign pk_ph = a_ls_q ? 2'h0 : pk_ph_q;
    always_comb begin
        emit = 1'b1;
        word = {16'h0000, pix16};
        if (pack888) begin
            unique case (pk_ph)
                2'h0: emit = 1'b0;
                2'h1: word = {rgb24[7:0], res_q[7:0], res_q[15:0]};
                2'h2: word = {rgb24[15:0], res_q[15:0]};
                default: word = {rgb24, res_q[7:0]};
            endcase
        end else if (fmt == VSF_FMT_RGB888) begin
            word = {8'h00, rgb24};
        end
    end
    assign word_bo = little ? word :
        {word[7:0], word[15:8], word[23:16], word[31:24]};
    assign cur_addr = a_fs_q ? (a_bot_q ? bot_q : top_q) : wptr_q;

    // residue: phase 0 keeps 24 bits (one reg would be wider), so
    // the first pixel is split between res_q and res_hi_q
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pk_ph_q <= 2'h0;
            res_q <= 16'h0000;
        end else if (a_en && pack888) begin
            pk_ph_q <= pk_ph + 2'h1;
            unique case (pk_ph)
                2'h0: res_q <= rgb24[15:0];
                2'h1: res_q <= rgb24[23:8];
                default: res_q <= {8'h00, rgb24[23:16]};
            endcase
        end
    end

    logic [7:0] res_hi_q;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            res_hi_q <= 8'h00;
        end else if (a_en && pack888 && pk_ph == 2'h0) begin
            res_hi_q <= rgb24[23:16];
        end
    end

    logic [31:0] word_out;
    assign word_out = (pack888 && pk_ph == 2'h1) ?
        (little ? {word_bo[31:24], res_hi_q, word_bo[15:0]} :
         {word_bo[31:16], res_hi_q, word_bo[7:0]}) : word_bo;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_valid_q <= 1'b0;
            wr_data_o <= 32'h00000000;
            wr_addr_o <= 32'h00000000;
            wptr_q <= 32'h00000000;
        end else if (adv) begin
            wr_valid_q <= a_valid_q && emit;
            if (a_valid_q && emit) begin
                wr_data_o <= word_out;
                wr_addr_o <= cur_addr;
                wptr_q <= cur_addr + VSF_WORD_STEP;
            end else if (a_valid_q && a_fs_q) begin
                wptr_q <= cur_addr;
            end
        end
    end
    assign wr_valid_o = wr_valid_q;

    AST_FILTER_DEFAULT: assert property (
        hsel > VSF_HF_T4B |-> luma_k == VSF_TAP_NONE &&
            chroma_k == VSF_TAP_3)
        else $error("reserved filter code not mapped to default");
    AST_NO_HDROP: assert property (
        acc_in && hdcm == 6'h00 && !line_drop && !field_drop |=> a_valid_q)
        else $error("pixel lost with zero horizontal decimation");
    AST_NO_VDROP: assert property (
        vdcm == 6'h00 |-> !vdrop)
        else $error("line dropped with zero vertical decimation");
    AST_SINGLE_FIELD: assert property (
        acc_in && disp_single && bot_now |=> !a_valid_q)
        else $error("bottom field pixel kept in single field mode");
    AST_ONE_PER_WORD: assert property (
        a_en && !pack888 |=> wr_valid_q)
        else $error("unpacked pixel did not make a word");
    AST_PACK_GAP: assert property (
        a_en && pack888 && pk_ph == 2'h0 |=> !wr_valid_q)
        else $error("packed phase zero emitted a word");
    AST_TOP_START: assert property (
        a_en && emit && a_fs_q && !a_bot_q |=>
            wr_addr_o == $past(top_q) && wr_addr_o[1:0] == 2'b00)
        else $error("top field did not start at top base");
    AST_BOT_START: assert property (
        a_en && emit && a_fs_q && a_bot_q |=>
            wr_addr_o == $past(bot_q) && wr_addr_o[1:0] == 2'b00)
        else $error("bottom field did not start at bottom base");
    AST_RSVD_ZERO: assert property (
        rvalid_q && rd_scaler_q |-> reg_rdata_o[VSF_RSVD_HI_BIT] == 1'b0 &&
            reg_rdata_o[VSF_RSVD_LO_BIT] == 1'b0)
        else $error("reserved scaler bit read as one");
    AST_LE_LOW_HALF: assert property (
        a_en && little && fmt == VSF_FMT_RGB565 |=>
            wr_data_o[31:16] == 16'h0000)
        else $error("little endian 16-bit pixel not in low half");
endmodule : vsf_top
`default_nettype wire

// ===== logic/vsf_top_note.sv
// intentionally empty companion unit
`default_nettype none
`default_nettype wire

// ===== sim/vsf_mem_model.sv
// display memory model: takes words, can stall, records the last one
`default_nettype none
module vsf_mem_model (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // write port
    input wire logic wr_valid_i,
    input wire logic [31:0] wr_data_i,
    input wire logic [31:0] wr_addr_i,
    input wire logic stall_i,
    output logic wr_ready_o,
    // observation
    output logic [31:0] cnt_o,
    output logic [31:0] data_o,
    output logic [31:0] addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // stalling alternates ready so words wait with valid held
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_ready_o <= 1'b1;
            cnt_o <= 32'h0;
        end else begin
            wr_ready_o <= stall_i ? ~wr_ready_o : 1'b1;
            if (wr_valid_i && wr_ready_o) begin
                cnt_o <= cnt_o + 32'h1;
                data_o <= wr_data_i;
                addr_o <= wr_addr_i;
            end
        end
    end
endmodule : vsf_mem_model
`default_nettype wire

// ===== sim/video_scaler_pixel_formatter_tb.sv
// self-checking bench of the scaler and pixel formatter
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module video_scaler_pixel_formatter_tb import vsf_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset, rw, rr, rv, pv, prdy, ls, fs, fb, wv, wrdy, stall;
    logic [11:0] ra;
    logic [31:0] wd, rdat, od, oa, cnt, md, ma, c0;
    logic [7:0] py = 8'h40;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    vsf_top uut (.sys_clk_i(sys_clk), .reset_i(reset), .reg_wr_i(rw),
        .reg_rd_i(rr), .reg_addr_i(ra), .reg_be_i(4'hf), .reg_wdata_i(wd),
        .reg_rdata_o(rdat), .reg_rvalid_o(rv), .pix_valid_i(pv),
        .pix_ready_o(prdy), .pix_y_i(py), .pix_c_i(8'h80),
        .pix_line_start_i(ls), .pix_field_start_i(fs),
        .pix_field_bottom_i(fb), .wr_valid_o(wv), .wr_ready_i(wrdy),
        .wr_data_o(od), .wr_addr_o(oa));
    vsf_mem_model mem (.sys_clk_i(sys_clk), .reset_i(reset),
        .wr_valid_i(wv), .wr_data_i(od), .wr_addr_i(oa), .stall_i(stall),
        .wr_ready_o(wrdy), .cnt_o(cnt), .data_o(md), .addr_o(ma));
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        ra <= a;
        wd <= v;
        rw <= 1'b1;
        @(posedge sys_clk);
        rw <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        ra <= a;
        rr <= 1'b1;
        @(posedge sys_clk);
        rr <= 1'b0;
        @(negedge sys_clk);
        `CHK(rv, 1'b1)
        `CHK(rdat, e)
    endtask : rd
    // config is only rewritten between lines, with the pipe drained
    function automatic logic [31:0] cfg(input logic [2:0] h, input logic u,
            input logic [5:0] hd, vd, input logic m, input logic [1:0] f,
            input logic p, e);
        return {8'h00, h, u, hd, vd, 1'b0, m, 1'b0, f, 1'b0, p, e};
    endfunction : cfg
    task automatic line(input int n, input logic f, b);
        c0 = cnt;
        @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            pv <= 1'b1;
            ls <= (i == 0);
            fs <= f && (i == 0);
            fb <= b;
            @(negedge sys_clk);
            while (prdy !== 1'b1) @(negedge sys_clk);
            @(posedge sys_clk);
        end
        pv <= 1'b0;
        repeat (16) @(posedge sys_clk);
    endtask : line
    task automatic t_regs();
        rd(VSF_OFS_SCALER, 32'h00000011);
        rd(VSF_OFS_TOP, 32'h0ffffffc);
        rd(VSF_OFS_BOT, 32'h0ffffffc);
        rd(12'h100, 32'h0);
        wr(VSF_OFS_SCALER, 32'hffffffff);
        rd(VSF_OFS_SCALER, 32'h00ffff5f);
        wr(VSF_OFS_TOP, 32'hffffffff);
        rd(VSF_OFS_TOP, 32'hfffffffc);
        wr(VSF_OFS_BOT, 32'h12345677);
        rd(VSF_OFS_BOT, 32'h12345674);
        wr(VSF_OFS_TOP, 32'h00001000);
    endtask : t_regs
    task automatic t_format();
        // a luma step after a dark run tells every filter apart except 4/4 from 4/4b
        logic [7:0] fy [8] = '{8'h40, 8'h30, 8'h20, 8'h18, 8'h20, 8'h40,
            8'h40, 8'h40};
        for (int h = 0; h < 8; h++) begin
            wr(VSF_OFS_SCALER,
                cfg(h, 0, 0, 0, 0, VSF_FMT_YUV, 0, 1));
            py <= 8'h00;
            line(6, 1, 0);
            py <= 8'h40;
            line(2, 0, 0);
            `CHK(cnt - c0, 32'd2)
            `CHK(md, {16'h0000, 8'h80, fy[h]})
            `CHK(ma, 32'h0000101c)
        end
        wr(VSF_OFS_SCALER, cfg(7, 0, 0, 0, 0, VSF_FMT_YUV, 1, 0));
        line(8, 1, 1);
        `CHK(md, 32'h40800000)
        `CHK(ma, 32'h12345690)
    endtask : t_format
    task automatic t_hdcm();
        logic [5:0] n [3] = '{6'd0, 6'd1, 6'd63};
        stall <= 1'b1;
        foreach (n[k]) begin
            wr(VSF_OFS_SCALER, cfg(0, 0, n[k], 0, 0, VSF_FMT_RGB565, 0, 1));
            line(64, 1, 0);
            `CHK(cnt - c0, 32'd64 - n[k])
        end
        stall <= 1'b0;
    endtask : t_hdcm
    task automatic t_vdcm();
        logic [31:0] s;
        for (int u = 0; u < 2; u++) begin
            wr(VSF_OFS_SCALER, cfg(0, u, 0, 62, 0, VSF_FMT_RGB565, 0, 1));
            s = cnt;
            // an interlaced bottom field starts its drop phase half a line ahead, so
            // its first line goes; the duplicated pass drives a top field, which keeps it
            for (int l = 0; l < 64; l++) begin
                line(1, l == 0, u == 0);
                if (l == 0) `CHK(cnt - s, (u == 1) ? 32'd1 : 32'd0)
            end
            `CHK(cnt - s, 32'd2)
        end
    endtask : t_vdcm
    task automatic t_mode();
        logic [31:0] dm = 32'h1 << VSF_DITH_BIT;
        wr(VSF_OFS_SCALER, cfg(0, 0, 0, 0, 1, VSF_FMT_RGB565, 1, 1));
        line(8, 1, 1);
        `CHK(cnt - c0, 32'd0)
        line(8, 1, 0);
        `CHK(cnt - c0, 32'd8)
        `CHK(md, 32'h00004208)
        wr(VSF_OFS_SCALER, cfg(0, 0, 0, 0, 0, VSF_FMT_RGB888, 1, 1));
        line(8, 1, 0);
        `CHK(cnt - c0, 32'd6)
        line(5, 1, 0);
        `CHK(cnt - c0, 32'd3)
        `CHK(md, 32'h40404040)
        // low bits 011 make the carried error show by the line's end
        py <= 8'h43;
        wr(VSF_OFS_SCALER, cfg(0, 0, 0, 0, 0, VSF_FMT_RGB565, 0, 1) | dm);
        line(8, 1, 0);
        `CHK(md, 32'h00004a29)
        wr(VSF_OFS_SCALER, cfg(0, 0, 0, 0, 0, VSF_FMT_RGB555, 0, 1) | dm);
        line(8, 1, 0);
        `CHK(md, 32'h00002529)
        wr(VSF_OFS_SCALER, cfg(0, 0, 0, 0, 0, VSF_FMT_RGB565, 0, 1));
        line(8, 1, 0);
        `CHK(md, 32'h00004208)
        wr(VSF_OFS_SCALER, cfg(0, 0, 0, 0, 0, VSF_FMT_RGB888, 0, 0) | dm);
        line(8, 1, 0);
        `CHK(md, 32'h43434300)
        `CHK(cnt - c0, 32'd8)
    endtask : t_mode
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            results();
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        {rw, rr, pv, ls, fs, fb, stall} = '0;
        ra = '0;
        wd = '0;
        reset = 1'b1;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        t_format();
        t_hdcm();
        t_vdcm();
        t_mode();
        results();
    end
endmodule : video_scaler_pixel_formatter_tb
`default_nettype wire
